// ### usdb_consts.svh
// Constants of the serial line status, data and divider registers.
// Assumes inclusion by bare name from the package and the register module.
`ifndef USDB_CONSTS_SVH
`define USDB_CONSTS_SVH

// ****************************************************************
// Register offsets, byte addresses
// ****************************************************************
`define USDB_OFF_STATUS 8'h00
`define USDB_OFF_WORD 8'h04
`define USDB_OFF_DIVIDER 8'h08
`define USDB_OFF_SETUP 8'h0C

// ****************************************************************
// Status flag positions
// ****************************************************************
`define USDB_PARITY_FAULT 0
`define USDB_FRAMING_FAULT 1
`define USDB_LINE_NOISE 2
`define USDB_RX_OVERRUN 3
`define USDB_LINE_QUIET 4
`define USDB_RX_FULL 5
`define USDB_SEND_FINISHED 6
`define USDB_SEND_FREE 7
`define USDB_LIN_BREAK 8
`define USDB_CTS_CHANGE 9
`define USDB_FLAG_COUNT 10

// ****************************************************************
// Field layouts and reset values
// ****************************************************************
`define USDB_WORD_WIDTH 9
`define USDB_FRAC_LSB 0
`define USDB_FRAC_MSB 3
`define USDB_INT_LSB 4
`define USDB_INT_MSB 15
`define USDB_SETUP_PARITY_ON 0
`define USDB_SETUP_PARITY_ODD 1
`define USDB_SETUP_NINE_BIT 2
`define USDB_SETUP_CTS_ON 3
`define USDB_STATUS_RESET 10'h0C0
`define USDB_DIVIDER_RESET 16'h0000
`define USDB_SETUP_RESET 4'h0
`define USDB_OVERSAMPLE 17'h00010

`endif

// ### usdb_pkg.sv
// Types shared by the serial line register block and its neighbours.
// Assumes the constants header is on the include path.
`include "usdb_consts.svh"

package usdb_pkg;

	// ****************************************************************
	// Received word with its line conditions
	// ****************************************************************
	typedef struct packed {
		logic valid;
		logic framing_fault;
		logic line_noise;
		logic [`USDB_WORD_WIDTH-1:0] word;
	} usdb_rx_evt_s;

	// ****************************************************************
	// Line setup seen by the framing logic
	// ****************************************************************
	typedef struct packed {
		logic clear_to_send_handling_on;
		logic nine_bit;
		logic parity_odd;
		logic parity_on;
	} usdb_setup_s;

endpackage

// ### usdb_regs.sv
// Status, data and bit rate divider registers of a serial transceiver.
// Assumes a framer and shifters on CLOCK_IN; only the CTS pin is asynchronous.
`timescale 1ns/1ns
`include "usdb_consts.svh"

module usdb_regs
(
	// Clock and reset
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	// Register port
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	output logic [31:0] RDATA_OUT,
	// Receive side
	input wire usdb_pkg::usdb_rx_evt_s RX_EVT_IN,
	input wire logic IDLE_SEEN_IN,
	input wire logic LIN_BREAK_IN,
	input wire logic CLEAR_TO_SEND_INPUT_LOW_IN,
	// Transmit side
	input wire logic TX_TAKE_IN,
	input wire logic TX_SHIFT_DONE_IN,
	output logic [`USDB_WORD_WIDTH-1:0] TX_WORD_OUT,
	output logic TX_PENDING_OUT,
	// Setup and oversampling tick
	output usdb_pkg::usdb_setup_s SETUP_OUT,
	output logic BAUD_TICK16_OUT
);
	import usdb_pkg::*;

	localparam logic [`USDB_FLAG_COUNT-1:0] STATUS_RST = `USDB_STATUS_RESET;

	logic [`USDB_FLAG_COUNT-1:0] line_status_r;
	logic [`USDB_FLAG_COUNT-1:0] flag_set;
	logic [`USDB_FLAG_COUNT-1:0] flag_clr;
	logic [4:0] seq_arm_r;
	logic finish_arm_r;
	logic [`USDB_WORD_WIDTH-1:0] rx_word_r;
	logic [`USDB_FRAC_MSB:`USDB_FRAC_LSB] divider_fraction_r;
	logic [`USDB_INT_MSB-`USDB_INT_LSB:0] divider_integer_r;
	logic [16:0] acc_r;
	logic [16:0] acc_sum;
	logic [16:0] div_full;
	logic cts_s1_r;
	logic cts_s2_r;
	logic cts_s3_r;
	logic sel_status;
	logic sel_word;
	logic sel_divider;
	logic sel_setup;
	logic rd_status;
	logic rd_word;
	logic wr_status;
	logic wr_word;
	logic wr_divider;
	logic rx_take;
	logic rx_overrun;
	logic parity_sum;
	logic parity_bad;
	logic [31:0] rdata_nxt;

	// ****************************************************************
	// Address decode
	// ****************************************************************
	assign sel_status = ADDR_IN == `USDB_OFF_STATUS;
	assign sel_word = ADDR_IN == `USDB_OFF_WORD;
	assign sel_divider = ADDR_IN == `USDB_OFF_DIVIDER;
	assign sel_setup = ADDR_IN == `USDB_OFF_SETUP;
	assign rd_status = RD_IN & sel_status;
	assign rd_word = RD_IN & sel_word;
	assign wr_status = WR_IN & sel_status;
	assign wr_word = WR_IN & sel_word;
	assign wr_divider = WR_IN & sel_divider;

	// ****************************************************************
	// Receive word checks
	// ****************************************************************
	assign rx_take = RX_EVT_IN.valid & ~line_status_r[`USDB_RX_FULL];
	assign rx_overrun = RX_EVT_IN.valid & line_status_r[`USDB_RX_FULL];
	always_comb
	begin
		if (SETUP_OUT.nine_bit)
		begin
			parity_sum = ^RX_EVT_IN.word;
		end
		else
		begin
			parity_sum = ^RX_EVT_IN.word[7:0];
		end
	end
	assign parity_bad = SETUP_OUT.parity_on & (parity_sum ^ SETUP_OUT.parity_odd);

	// ****************************************************************
	// Flag set and clear terms
	// ****************************************************************
	always_comb
	begin
		flag_set = '0;
		flag_set[`USDB_PARITY_FAULT] = rx_take & parity_bad;
		flag_set[`USDB_FRAMING_FAULT] = rx_take & RX_EVT_IN.framing_fault;
		flag_set[`USDB_LINE_NOISE] = rx_take & RX_EVT_IN.line_noise;
		flag_set[`USDB_RX_OVERRUN] = rx_overrun;
		flag_set[`USDB_LINE_QUIET] = IDLE_SEEN_IN;
		flag_set[`USDB_RX_FULL] = rx_take;
		flag_set[`USDB_SEND_FINISHED] = TX_SHIFT_DONE_IN
			& line_status_r[`USDB_SEND_FREE];
		flag_set[`USDB_SEND_FREE] = TX_TAKE_IN & ~wr_word;
		flag_set[`USDB_LIN_BREAK] = LIN_BREAK_IN;
		flag_set[`USDB_CTS_CHANGE] = SETUP_OUT.clear_to_send_handling_on
			& (cts_s2_r ^ cts_s3_r);
	end

	always_comb
	begin
		flag_clr = '0;
		flag_clr[4:0] = {5{rd_word}} & seq_arm_r;
		flag_clr[`USDB_RX_FULL] = rd_word
			| (wr_status & ~WDATA_IN[`USDB_RX_FULL]);
		flag_clr[`USDB_SEND_FINISHED] = (wr_word & finish_arm_r)
			| (wr_status & ~WDATA_IN[`USDB_SEND_FINISHED]);
		flag_clr[`USDB_SEND_FREE] = wr_word;
		flag_clr[`USDB_LIN_BREAK] = wr_status & ~WDATA_IN[`USDB_LIN_BREAK];
		flag_clr[`USDB_CTS_CHANGE] = wr_status & ~WDATA_IN[`USDB_CTS_CHANGE];
	end

	// ****************************************************************
	// Status flags, set wins over clear; for send free a word write beats the take
	// ****************************************************************
	genvar gi;
	generate
		for (gi = 0; gi < `USDB_FLAG_COUNT; gi++)
		begin : g_flag
			always_ff @(posedge CLOCK_IN)
			begin
				if (!NRST_IN)
				begin
					line_status_r[gi] <= STATUS_RST[gi];
				end
				else
				begin
					line_status_r[gi] <= flag_set[gi]
						| (line_status_r[gi] & ~flag_clr[gi]);
				end
			end
		end
	endgenerate

	// ****************************************************************
	// Status-read arming for the two-step clears
	// ****************************************************************
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			seq_arm_r <= 5'h00;
		end
		else if (rd_status)
		begin
			seq_arm_r <= line_status_r[4:0];
		end
		else if (rd_word)
		begin
			seq_arm_r <= 5'h00;
		end
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			finish_arm_r <= 1'b0;
		end
		else if (rd_status)
		begin
			finish_arm_r <= line_status_r[`USDB_SEND_FINISHED];
		end
		else if (wr_word)
		begin
			finish_arm_r <= 1'b0;
		end
	end

	// ****************************************************************
	// Receive data register, left without reset
	// ****************************************************************
	always_ff @(posedge CLOCK_IN)
	begin
		if (rx_take)
		begin
			rx_word_r <= RX_EVT_IN.word;
		end
	end

	// ****************************************************************
	// Transmit data register
	// ****************************************************************
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			TX_WORD_OUT <= '0;
		end
		else if (wr_word)
		begin
			TX_WORD_OUT <= WDATA_IN[`USDB_WORD_WIDTH-1:0];
		end
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			TX_PENDING_OUT <= 1'b0;
		end
		else
		begin
			TX_PENDING_OUT <= wr_word | (TX_PENDING_OUT & ~TX_TAKE_IN);
		end
	end

	// ****************************************************************
	// Divider and setup registers
	// ****************************************************************
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			{divider_integer_r, divider_fraction_r} <= `USDB_DIVIDER_RESET;
		end
		else if (wr_divider)
		begin
			divider_fraction_r <= WDATA_IN[`USDB_FRAC_MSB:`USDB_FRAC_LSB];
			divider_integer_r <= WDATA_IN[`USDB_INT_MSB:`USDB_INT_LSB];
		end
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			SETUP_OUT <= `USDB_SETUP_RESET;
		end
		else if (WR_IN & sel_setup)
		begin
			SETUP_OUT.parity_on <= WDATA_IN[`USDB_SETUP_PARITY_ON];
			SETUP_OUT.parity_odd <= WDATA_IN[`USDB_SETUP_PARITY_ODD];
			SETUP_OUT.nine_bit <= WDATA_IN[`USDB_SETUP_NINE_BIT];
			SETUP_OUT.clear_to_send_handling_on <= WDATA_IN[`USDB_SETUP_CTS_ON];
		end
	end

	// ****************************************************************
	// Fractional oversampling tick generator
	// ****************************************************************
	assign div_full = {1'b0, divider_integer_r, divider_fraction_r};
	assign acc_sum = acc_r + `USDB_OVERSAMPLE;

	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			acc_r <= '0;
			BAUD_TICK16_OUT <= 1'b0;
		end
		else if (wr_divider || div_full < `USDB_OVERSAMPLE)
		begin
			acc_r <= '0;
			BAUD_TICK16_OUT <= 1'b0;
		end
		else if (acc_sum >= div_full)
		begin
			acc_r <= acc_sum - div_full;
			BAUD_TICK16_OUT <= 1'b1;
		end
		else
		begin
			acc_r <= acc_sum;
			BAUD_TICK16_OUT <= 1'b0;
		end
	end

	// ****************************************************************
	// Clear-to-send pin synchroniser
	// ****************************************************************
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			cts_s1_r <= 1'b1;
			cts_s2_r <= 1'b1;
		end
		else
		begin
			cts_s1_r <= CLEAR_TO_SEND_INPUT_LOW_IN;
			cts_s2_r <= cts_s1_r;
		end
	end

	// ****************************************************************
	// Clear-to-send change detector, idle level after reset
	// ****************************************************************
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			cts_s3_r <= 1'b1;
		end
		else
		begin
			cts_s3_r <= cts_s2_r;
		end
	end

	// ****************************************************************
	// Read data path
	// ****************************************************************
	always_comb
	begin
		rdata_nxt = 32'h00000000;
		if (RD_IN)
		begin
			if (sel_status)
			begin
				rdata_nxt[`USDB_FLAG_COUNT-1:0] = line_status_r;
			end
			else if (sel_word)
			begin
				rdata_nxt[`USDB_WORD_WIDTH-1:0] = rx_word_r;
			end
			else if (sel_divider)
			begin
				rdata_nxt[`USDB_INT_MSB:0] = div_full[15:0];
			end
			else if (sel_setup)
			begin
				rdata_nxt[3:0] = SETUP_OUT;
			end
		end
	end

	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			RDATA_OUT <= 32'h00000000;
		end
		else
		begin
			RDATA_OUT <= rdata_nxt;
		end
	end

endmodule

// ### usdb_regs_sva.sv
// Concurrent checks on the serial line register block.
// Assumes binding to usdb_regs; sees only its ports.
`timescale 1ns/1ns
module usdb_regs_sva
(
	// Clock and reset
	input wire logic CLOCK_IN,
	input wire logic NRST_IN,
	// Register port
	input wire logic [7:0] ADDR_IN,
	input wire logic [31:0] WDATA_IN,
	input wire logic WR_IN,
	input wire logic RD_IN,
	input wire logic [31:0] RDATA_OUT,
	// Line side
	input wire usdb_pkg::usdb_rx_evt_s RX_EVT_IN,
	input wire logic TX_TAKE_IN,
	input wire logic [8:0] TX_WORD_OUT,
	input wire logic TX_PENDING_OUT,
	input wire usdb_pkg::usdb_setup_s SETUP_OUT,
	input wire logic BAUD_TICK16_OUT
);
	import usdb_pkg::*;
	logic [15:0] div_r;
	default clocking @(posedge CLOCK_IN);
	endclocking
	default disable iff (!NRST_IN);
	// ****************************************************************
	// Divider shadow and checks
	// ****************************************************************
	always_ff @(posedge CLOCK_IN)
	begin
		if (!NRST_IN)
		begin
			div_r <= 16'h0000;
		end
		else if (WR_IN && ADDR_IN == 8'h08)
		begin
			div_r <= WDATA_IN[15:0];
		end
	end
	AST_WORD_WRITE: assert property (WR_IN && ADDR_IN == 8'h04 |=>
		TX_PENDING_OUT && TX_WORD_OUT == $past(WDATA_IN[8:0])) else $error("word not queued");
	AST_TAKE: assert property (TX_TAKE_IN && !WR_IN |=> !TX_PENDING_OUT)
		else $error("pending after take");
	AST_STATUS_RSVD: assert property (RD_IN && ADDR_IN == 8'h00 |=> RDATA_OUT[31:10] == 22'h0)
		else $error("status reserved bits set");
	AST_WORD_RSVD: assert property (RD_IN && ADDR_IN == 8'h04 |=> RDATA_OUT[31:9] == 23'h0)
		else $error("word reserved bits set");
	AST_DIV_READ: assert property (RD_IN && ADDR_IN == 8'h08 |=> RDATA_OUT == {16'h0, div_r})
		else $error("divider readback wrong");
	AST_UNMAPPED: assert property (RD_IN && ADDR_IN > 8'h0C |=> RDATA_OUT == 32'h0)
		else $error("unmapped read not zero");
	AST_RDATA_IDLE: assert property (!RD_IN |=> RDATA_OUT == 32'h0)
		else $error("read data not zero outside read");
	AST_NO_TICK: assert property ($stable(div_r) && div_r < 16'h0010 |-> !BAUD_TICK16_OUT)
		else $error("tick with small divider");
	AST_TICK_GAP: assert property (div_r >= 16'h0020 && $stable(div_r) && BAUD_TICK16_OUT |=>
		!BAUD_TICK16_OUT) else $error("ticks too close");
	AST_RX_FULL: assert property (RX_EVT_IN.valid && !RD_IN && !WR_IN ##1 !RD_IN && !WR_IN ##1
		(RD_IN && ADDR_IN == 8'h00) |=> RDATA_OUT[5]) else $error("receive full not set");
	AST_SETUP: assert property (WR_IN && ADDR_IN == 8'h0C |=> SETUP_OUT == $past(WDATA_IN[3:0]))
		else $error("setup not stored");
	cover property (TX_TAKE_IN);
	cover property (BAUD_TICK16_OUT);
	cover property (RX_EVT_IN.valid);
endmodule
bind usdb_regs usdb_regs_sva usdb_regs_sva_i (.CLOCK_IN, .NRST_IN, .ADDR_IN, .WDATA_IN, .WR_IN,
	.RD_IN, .RDATA_OUT, .RX_EVT_IN, .TX_TAKE_IN, .TX_WORD_OUT, .TX_PENDING_OUT, .SETUP_OUT,
	.BAUD_TICK16_OUT);

// ### usdb_node.sv
// Remote serial node as seen through the framer: words, line events, CTS pin.
// Assumes the caller clocks it with the register block clock.
`timescale 1ns/1ns
module usdb_node
(
	// Clock
	input wire logic clk_in,
	// Line events: idle, LIN break, shifter take, shift done
	output usdb_pkg::usdb_rx_evt_s evt_out,
	output logic [3:0] pulse_out,
	output logic cts_low_out
);
	import usdb_pkg::*;
	initial
	begin
		evt_out = '0;
		pulse_out = 4'h0;
		cts_low_out = 1'b1;
	end
	task automatic rx(input logic [8:0] w, input logic f, input logic n);
		@(posedge clk_in);
		evt_out <= {1'b1, f, n, w};
		@(posedge clk_in);
		evt_out <= {1'b0, ~f, ~n, ~w};
	endtask
	task automatic pulse(input int i);
		@(posedge clk_in);
		pulse_out[i] <= 1'b1;
		@(posedge clk_in);
		pulse_out <= 4'h0;
	endtask
	task automatic cts(input logic v);
		@(posedge clk_in);
		cts_low_out <= v;
	endtask
endmodule

// ### test_usdb_regs.sv
// Self-checking bench for the serial line register block.
// Assumes the node model and the bound checker are compiled alongside.
`timescale 1ns/1ns
module test_usdb_regs;
	import usdb_pkg::*;
	logic clk = 1'b0;
	logic nrst;
	logic wr;
	logic rd;
	logic [7:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [8:0] tx_word;
	logic tx_pend;
	logic tick;
	logic cts_low;
	logic [3:0] pulses;
	usdb_setup_s setup;
	usdb_rx_evt_s evt;
	int n_fail = 0;
	int n_checks = 0;
	int cyc = 0;
	int ticks;
	always #5 clk = ~clk;
	usdb_regs usdb_regs_i (.CLOCK_IN(clk), .NRST_IN(nrst), .ADDR_IN(addr), .WDATA_IN(wdata),
		.WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata), .RX_EVT_IN(evt), .IDLE_SEEN_IN(pulses[0]),
		.LIN_BREAK_IN(pulses[1]), .CLEAR_TO_SEND_INPUT_LOW_IN(cts_low), .TX_TAKE_IN(pulses[2]),
		.TX_SHIFT_DONE_IN(pulses[3]), .TX_WORD_OUT(tx_word), .TX_PENDING_OUT(tx_pend),
		.SETUP_OUT(setup), .BAUD_TICK16_OUT(tick));
	usdb_node usdb_node_i (.clk_in(clk), .evt_out(evt), .pulse_out(pulses), .cts_low_out(cts_low));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask
	task automatic rd32(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic count_ticks;
		ticks = 0;
		repeat (64)
		begin
			@(negedge clk);
			ticks += int'(tick);
		end
	endtask
	task automatic stop_test;
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 2000)
		begin
			n_fail++;
			stop_test();
		end
	end
	initial
	begin
		nrst <= 1'b0;
		wr <= 1'b0;
		rd <= 1'b0;
		addr <= 8'h00;
		wdata <= 32'h0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		rd32(8'h00, 32'h0C0);
		rd32(8'h08, 32'h0);
		wr32(8'h08, 32'hFFFFFFFF);
		rd32(8'h08, 32'h0000FFFF);
		wr32(8'h0C, 32'h5);
		chk({28'h0, setup}, 32'h5);
		usdb_node_i.rx(9'h1A5, 1'b1, 1'b1);
		usdb_node_i.rx(9'h0F0, 1'b0, 1'b0);
		usdb_node_i.pulse(0);
		rd32(8'h00, 32'h0FF);
		rd32(8'h04, 32'h1A5);
		rd32(8'h00, 32'h0C0);
		wr32(8'h0C, 32'h3);
		usdb_node_i.rx(9'h103, 1'b0, 1'b0);
		rd32(8'h00, 32'h0E1);
		wr32(8'h00, 32'h3DF);
		rd32(8'h00, 32'h0C1);
		rd32(8'h04, 32'h103);
		rd32(8'h00, 32'h0C0);
		usdb_node_i.rx(9'h007, 1'b0, 1'b0);
		rd32(8'h00, 32'h0E0);
		rd32(8'h04, 32'h007);
		wr32(8'h04, 32'hFFFFFE55);
		chk({23'h0, tx_word}, 32'h055);
		chk({31'h0, tx_pend}, 32'h1);
		rd32(8'h00, 32'h000);
		usdb_node_i.pulse(2);
		rd32(8'h00, 32'h080);
		chk({31'h0, tx_pend}, 32'h0);
		usdb_node_i.pulse(3);
		rd32(8'h00, 32'h0C0);
		wr32(8'h00, 32'h3BF);
		rd32(8'h00, 32'h080);
		usdb_node_i.pulse(1);
		rd32(8'h00, 32'h180);
		wr32(8'h00, 32'h2FF);
		rd32(8'h00, 32'h080);
		usdb_node_i.cts(1'b0);
		repeat (6) @(posedge clk);
		rd32(8'h00, 32'h080);
		wr32(8'h0C, 32'h8);
		usdb_node_i.cts(1'b1);
		repeat (6) @(posedge clk);
		rd32(8'h00, 32'h280);
		wr32(8'h00, 32'h1FF);
		rd32(8'h00, 32'h080);
		usdb_node_i.pulse(1);
		@(posedge clk);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		rd32(8'h00, 32'h0C0);
		rd32(8'h08, 32'h0);
		wr32(8'h10, 32'hFFFFFFFF);
		rd32(8'h10, 32'h0);
		wr32(8'h08, 32'h20);
		count_ticks();
		chk({31'h0, ticks >= 31 && ticks <= 33}, 32'h1);
		wr32(8'h08, 32'h0F);
		count_ticks();
		chk(ticks, 32'h0);
		stop_test();
	end
endmodule
